// *** ntwr_regs.sv ***
// Tuning word and phase shift register bank with its phase accumulator.
//
// Decided for this implementation: the AXI4-Lite register port.
module ntwr_regs #(
  parameter int ADDR_W = 16,
  parameter int STEP_W = 48,
  parameter int SHIFT_W = 24
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator side.
  output logic [STEP_W-1:0] nco_freq_step,
  output logic [SHIFT_W-1:0] nco_phase_shift,
  output logic [3:0] nco_update_index,
  output logic nco_update_pulse,
  output logic [STEP_W-1:0] nco_phase
);

  // Turns a byte address into a word index.
  function automatic logic [11:0] to_index(input logic [ADDR_W-1:0] addr);
    to_index = addr[13:2];
  endfunction : to_index

  // Tells whether an index names a mapped register.
  function automatic logic is_mapped(input logic [11:0] idx);
    is_mapped = ((idx >= ntwr_pkg::IDX_STEP_BYTE0) && (idx <= ntwr_pkg::IDX_STEP_BYTE5))
             || ((idx >= ntwr_pkg::IDX_SHIFT_BYTE0) && (idx <= ntwr_pkg::IDX_UPDATE_STAT));
  endfunction : is_mapped

  // Software-visible word bytes, shadow copies of what the oscillator uses.
  logic [7:0] step_byte_ff [ntwr_pkg::STEP_BYTES];
  logic [7:0] shift_byte_ff [ntwr_pkg::SHIFT_BYTES];
  logic mode_ff;
  logic [3:0] index_ff;
  logic pending_ff;

  // Write channel state.
  ntwr_pkg::ntwr_wr_state_t wr_state_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff;

  // Read channel state.
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Update path state.
  logic wrote_ff;
  logic xfer_ff;
  logic pulse_ff;
  logic [STEP_W-1:0] active_step_ff;
  logic [SHIFT_W-1:0] active_shift_ff;
  logic [STEP_W-1:0] acc_ff;
  logic [STEP_W-1:0] phase_ff;

  // Decoded write strobes.
  logic do_write;
  logic [11:0] wr_idx;
  logic lane0;
  logic word_wr;
  logic xfer_wr;
  logic [STEP_W-1:0] shadow_step;
  logic [SHIFT_W-1:0] shadow_shift;

  // Channel handshakes: each address and data beat is taken once per write.
  assign s_axi_awready = (wr_state_ff == ntwr_pkg::WR_COLLECT) && !aw_hold_ff;
  assign s_axi_wready = (wr_state_ff == ntwr_pkg::WR_COLLECT) && !w_hold_ff;
  assign s_axi_bvalid = (wr_state_ff == ntwr_pkg::WR_RESP);
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // The write is carried out once both address and data are held.
  assign do_write = (wr_state_ff == ntwr_pkg::WR_COLLECT) && aw_hold_ff && w_hold_ff;
  assign wr_idx = to_index(awaddr_ff);
  assign lane0 = wstrb_ff[0];
  assign word_wr = do_write && lane0
                && (((wr_idx >= ntwr_pkg::IDX_STEP_BYTE0) && (wr_idx <= ntwr_pkg::IDX_STEP_BYTE5))
                 || ((wr_idx >= ntwr_pkg::IDX_SHIFT_BYTE0) && (wr_idx <= ntwr_pkg::IDX_SHIFT_BYTE2)));
  assign xfer_wr = do_write && lane0 && (wr_idx == ntwr_pkg::IDX_UPDATE_XFER)
                && wdata_ff[ntwr_pkg::XFER_GO_BIT];

  // Assemble the shadow words, lowest byte at the lowest index.
  always_comb begin
    shadow_step = {step_byte_ff[5], step_byte_ff[4], step_byte_ff[3],
                   step_byte_ff[2], step_byte_ff[1], step_byte_ff[0]};
    shadow_shift = {shift_byte_ff[2], shift_byte_ff[1], shift_byte_ff[0]};
  end

  // Write channel sequencing: collect address and data, then answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= ntwr_pkg::WR_COLLECT;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bresp_ff <= ntwr_pkg::RESP_OKAY;
    end else begin
      case (wr_state_ff)
        ntwr_pkg::WR_COLLECT: begin
          if (do_write) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bresp_ff <= is_mapped(wr_idx) ? ntwr_pkg::RESP_OKAY : ntwr_pkg::RESP_SLVERR;
            wr_state_ff <= ntwr_pkg::WR_RESP;
          end else begin
            if (s_axi_awvalid && s_axi_awready) begin
              aw_hold_ff <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
              w_hold_ff <= 1'b1;
            end
          end
        end
        ntwr_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_ff <= ntwr_pkg::WR_COLLECT;
          end
        end
        default: begin
          wr_state_ff <= ntwr_pkg::WR_COLLECT;
        end
      endcase
    end
  end

  // Capture the write address and data beats.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // Tuning word bytes: each byte sits in the low lane of its own word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ntwr_pkg::STEP_BYTES; i++) begin
        step_byte_ff[i] <= ntwr_pkg::BYTE_RESET;
      end
    end else if (word_wr) begin
      if (wr_idx == ntwr_pkg::IDX_STEP_BYTE0) begin
        step_byte_ff[0] <= wdata_ff[7:0];
      end else if (wr_idx == ntwr_pkg::IDX_STEP_BYTE1) begin
        step_byte_ff[1] <= wdata_ff[7:0];
      end else if (wr_idx == ntwr_pkg::IDX_STEP_BYTE2) begin
        step_byte_ff[2] <= wdata_ff[7:0];
      end else if (wr_idx == ntwr_pkg::IDX_STEP_BYTE3) begin
        step_byte_ff[3] <= wdata_ff[7:0];
      end else if (wr_idx == ntwr_pkg::IDX_STEP_BYTE4) begin
        step_byte_ff[4] <= wdata_ff[7:0];
      end else if (wr_idx == ntwr_pkg::IDX_STEP_BYTE5) begin
        step_byte_ff[5] <= wdata_ff[7:0];
      end
    end
  end

  // Phase shift bytes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ntwr_pkg::SHIFT_BYTES; i++) begin
        shift_byte_ff[i] <= ntwr_pkg::BYTE_RESET;
      end
    end else if (word_wr) begin
      if (wr_idx == ntwr_pkg::IDX_SHIFT_BYTE0) begin
        shift_byte_ff[0] <= wdata_ff[7:0];
      end else if (wr_idx == ntwr_pkg::IDX_SHIFT_BYTE1) begin
        shift_byte_ff[1] <= wdata_ff[7:0];
      end else if (wr_idx == ntwr_pkg::IDX_SHIFT_BYTE2) begin
        shift_byte_ff[2] <= wdata_ff[7:0];
      end
    end
  end

  // Update mode and channel index.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= ntwr_pkg::MODE_RESET;
      index_ff <= ntwr_pkg::INDEX_RESET;
    end else if (do_write && lane0 && (wr_idx == ntwr_pkg::IDX_UPDATE_CTRL)) begin
      mode_ff <= wdata_ff[ntwr_pkg::CTRL_MODE_BIT];
      index_ff <= wdata_ff[ntwr_pkg::CTRL_INDEX_LSB +: ntwr_pkg::CTRL_INDEX_W];
    end
  end

  // Pending flag: a word write in transfer mode waits for a transfer; a new write wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_ff <= 1'b0;
    end else if (word_wr && mode_ff) begin
      pending_ff <= 1'b1;
    end else if (xfer_wr || !mode_ff) begin
      pending_ff <= 1'b0;
    end
  end

  // Read channel: answer one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= ntwr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= is_mapped(to_index(s_axi_araddr)) ? ntwr_pkg::RESP_OKAY : ntwr_pkg::RESP_SLVERR;
      rdata_ff <= 32'h0000_0000;
      if (to_index(s_axi_araddr) == ntwr_pkg::IDX_STEP_BYTE0) begin
        rdata_ff[7:0] <= step_byte_ff[0];
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_STEP_BYTE1) begin
        rdata_ff[7:0] <= step_byte_ff[1];
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_STEP_BYTE2) begin
        rdata_ff[7:0] <= step_byte_ff[2];
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_STEP_BYTE3) begin
        rdata_ff[7:0] <= step_byte_ff[3];
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_STEP_BYTE4) begin
        rdata_ff[7:0] <= step_byte_ff[4];
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_STEP_BYTE5) begin
        rdata_ff[7:0] <= step_byte_ff[5];
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_SHIFT_BYTE0) begin
        rdata_ff[7:0] <= shift_byte_ff[0];
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_SHIFT_BYTE1) begin
        rdata_ff[7:0] <= shift_byte_ff[1];
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_SHIFT_BYTE2) begin
        rdata_ff[7:0] <= shift_byte_ff[2];
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_UPDATE_CTRL) begin
        rdata_ff[ntwr_pkg::CTRL_MODE_BIT] <= mode_ff;
        rdata_ff[ntwr_pkg::CTRL_INDEX_LSB +: ntwr_pkg::CTRL_INDEX_W] <= index_ff;
      end else if (to_index(s_axi_araddr) == ntwr_pkg::IDX_UPDATE_STAT) begin
        rdata_ff[ntwr_pkg::STAT_PENDING_BIT] <= pending_ff;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Delay the write events by one cycle so the shadow bytes have settled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrote_ff <= 1'b0;
      xfer_ff <= 1'b0;
    end else begin
      wrote_ff <= word_wr;
      xfer_ff <= xfer_wr;
    end
  end

  // Apply the shadow words: every cycle in continuous mode, on transfer otherwise.
  // In continuous mode a shadow that differs from the active words also pulses, so
  // leaving transfer mode with a pending word still announces the load it causes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_step_ff <= '0;
      active_shift_ff <= '0;
      pulse_ff <= 1'b0;
    end else begin
      if (!mode_ff || xfer_ff) begin
        active_step_ff <= shadow_step;
        active_shift_ff <= shadow_shift;
      end
      if (mode_ff) begin
        pulse_ff <= xfer_ff;
      end else begin
        pulse_ff <= wrote_ff || (shadow_step != active_step_ff)
                 || (shadow_shift != active_shift_ff);
      end
    end
  end

  // The accumulator adds the signed step each sample and wraps modulo 2^48.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= acc_ff + active_step_ff;
    end
  end

  // The signed shift is aligned to the top of the phase and added to it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff <= '0;
    end else begin
      phase_ff <= acc_ff + {active_shift_ff, {(STEP_W - SHIFT_W){1'b0}}};
    end
  end

  // Oscillator outputs.
  assign nco_freq_step = active_step_ff;
  assign nco_phase_shift = active_shift_ff;
  assign nco_update_index = index_ff;
  assign nco_update_pulse = pulse_ff;
  assign nco_phase = phase_ff;

endmodule : ntwr_regs

// *** ntwr_pkg.sv ***
// Constants shared by the oscillator tuning register bank.
package ntwr_pkg;

  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [11:0] IDX_STEP_BYTE0 = 12'h316;
  localparam logic [11:0] IDX_STEP_BYTE1 = 12'h317;
  localparam logic [11:0] IDX_STEP_BYTE2 = 12'h318;
  localparam logic [11:0] IDX_STEP_BYTE3 = 12'h319;
  localparam logic [11:0] IDX_STEP_BYTE4 = 12'h31a;
  localparam logic [11:0] IDX_STEP_BYTE5 = 12'h31b;
  localparam logic [11:0] IDX_SHIFT_BYTE0 = 12'h31d;
  localparam logic [11:0] IDX_SHIFT_BYTE1 = 12'h31e;
  localparam logic [11:0] IDX_SHIFT_BYTE2 = 12'h31f;
  localparam logic [11:0] IDX_UPDATE_CTRL = 12'h320;
  localparam logic [11:0] IDX_UPDATE_XFER = 12'h321;
  localparam logic [11:0] IDX_UPDATE_STAT = 12'h322;

  // Field positions inside the update control, transfer and status registers.
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_INDEX_LSB = 4;
  localparam int CTRL_INDEX_W = 4;
  localparam int XFER_GO_BIT = 0;
  localparam int STAT_PENDING_BIT = 0;

  // Byte counts of the words and the width of a byte.
  localparam int STEP_BYTES = 6;
  localparam int SHIFT_BYTES = 3;
  localparam int BYTE_W = 8;

  // Reset values.
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] INDEX_RESET = 4'h0;
  localparam logic MODE_RESET = 1'b0;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write channel states.
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } ntwr_wr_state_t;

endpackage : ntwr_pkg

// *** ntwr_props.sv ***
// Checker for the bus handshakes and oscillator outputs of the tuning register bank.
module ntwr_props #(
  parameter int STEP_W = 48,
  parameter int SHIFT_W = 24
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator side.
  input wire logic [STEP_W-1:0] nco_freq_step,
  input wire logic [SHIFT_W-1:0] nco_phase_shift,
  input wire logic nco_update_pulse,
  input wire logic [STEP_W-1:0] nco_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks share the bus clock and are quiet during reset.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // A response must stand unchanged until the host takes it.
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before it was taken");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before it was taken");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data is pending");
  // A write answers two edges after its handshakes, a read one edge after.
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  // Active words only move together with a single-cycle load pulse.
  pulse_width_a: assert property (nco_update_pulse |=> !nco_update_pulse)
    else $error("load pulse longer than one cycle");
  load_pulse_a: assert property ($changed(nco_freq_step) || $changed(nco_phase_shift) |-> nco_update_pulse)
    else $error("active words changed without a load pulse");
  // The phase grows by the signed step each sample while the shift stays put.
  phase_step_a: assert property ($stable(nco_phase_shift) |=> nco_phase == $past(nco_phase) + $past(nco_freq_step, 2))
    else $error("phase did not advance by the tuning word");
endmodule : ntwr_props

bind ntwr_regs ntwr_props #(.STEP_W(STEP_W), .SHIFT_W(SHIFT_W)) i_ntwr_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .nco_freq_step, .nco_phase_shift,
  .nco_update_pulse, .nco_phase
);

// *** ntwr_host.sv ***
// Bus master model that stands in for the host programming the tuning registers.
module ntwr_host (
  // Clock.
  input wire logic aclk,
  // Write channels.
  output logic [15:0] s_axi_awaddr = 16'h0,
  output logic s_axi_awvalid = 1'b0,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic [3:0] s_axi_wstrb = 4'h0,
  output logic s_axi_wvalid = 1'b0,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  // Read channels.
  output logic [15:0] s_axi_araddr = 16'h0,
  output logic s_axi_arvalid = 1'b0,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Offers address and data together and drops each once it is taken; entered after an edge.
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] strb,
                    output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk); // A fresh edge keeps the last call's release apart from this request.
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Holds the read address until taken, then waits for the data.
  task automatic rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk); // A fresh edge keeps the last call's release apart from this request.
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : ntwr_host

// *** ntwr_regs_tb.sv ***
// Self-checking testbench for the tuning register bank.
module ntwr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, nco_update_index;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, nco_update_pulse;
  logic [47:0] nco_freq_step, nco_phase;
  logic [23:0] nco_phase_shift;
  logic [31:0] d;
  int fails = 0;
  int n_tests = 0;
  // Word byte indexes and the values written to them.
  logic [11:0] bi [9] = '{12'h316, 12'h317, 12'h318, 12'h319, 12'h31a, 12'h31b, 12'h31d,
                          12'h31e, 12'h31f};
  logic [7:0] bv [9] = '{8'h01, 8'h23, 8'h45, 8'h67, 8'h89, 8'hab, 8'hcd, 8'hef, 8'h5a};

  // The 8 ns clock.
  always #4 aclk = ~aclk;

  ntwr_regs i_ntwr_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nco_freq_step,
    .nco_phase_shift, .nco_update_index, .nco_update_pulse, .nco_phase);
  ntwr_host i_ntwr_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // Compares one observed value with its expectation.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Waits four cycles and counts the load pulses seen at those edges.
  task automatic wait_pulses(output int n);
    n = 0;
    repeat (4) begin
      @(posedge aclk);
      n += int'(nco_update_pulse);
    end
  endtask : wait_pulses

  // Every word byte reads zero after reset.
  task automatic t_reset_values;
    for (int i = 0; i < 9; i++) begin
      i_ntwr_host.rd(bi[i], d, r);
      chk(64'(d), 64'h0);
    end
  endtask : t_reset_values

  // Bytes read back, assemble into a negative step, and drive the phase.
  task automatic t_bytes;
    logic [47:0] p0;
    logic [47:0] dp;
    for (int i = 0; i < 9; i++) begin
      i_ntwr_host.wr(bi[i], bv[i], 4'h1, r);
      chk(64'(r), 64'(ntwr_pkg::RESP_OKAY));
    end
    for (int i = 0; i < 9; i++) begin
      i_ntwr_host.rd(bi[i], d, r);
      chk(64'(d), 64'(bv[i]));
    end
    repeat (4) @(posedge aclk);
    chk(64'(nco_freq_step), 64'hab8967452301);
    chk(64'(nco_phase_shift), 64'h5aefcd);
    p0 = nco_phase;
    @(posedge aclk);
    dp = nco_phase - p0;
    chk(64'(dp), 64'hab8967452301);
  endtask : t_bytes

  // The gap index and a write without its byte strobe change nothing.
  task automatic t_refused;
    i_ntwr_host.wr(12'h31c, 8'h77, 4'h1, r);
    chk(64'(r), 64'(ntwr_pkg::RESP_SLVERR));
    i_ntwr_host.rd(12'h31c, d, r);
    chk({d, 30'h0, r}, {32'h0, 30'h0, ntwr_pkg::RESP_SLVERR});
    i_ntwr_host.wr(ntwr_pkg::IDX_SHIFT_BYTE0, 8'h00, 4'h0, r);
    chk(64'(r), 64'(ntwr_pkg::RESP_OKAY));
    i_ntwr_host.rd(ntwr_pkg::IDX_SHIFT_BYTE0, d, r);
    chk(64'(d), 64'hcd);
  endtask : t_refused

  // In transfer mode a new step waits for the transfer write.
  task automatic t_transfer;
    int p;
    i_ntwr_host.wr(ntwr_pkg::IDX_UPDATE_CTRL, 8'h31, 4'h1, r);
    i_ntwr_host.wr(ntwr_pkg::IDX_STEP_BYTE0, 8'h10, 4'h1, r);
    wait_pulses(p);
    chk(64'(p), 64'h0);
    chk(64'(nco_freq_step), 64'hab8967452301);
    i_ntwr_host.rd(ntwr_pkg::IDX_UPDATE_STAT, d, r);
    chk(64'(d), 64'h1);
    i_ntwr_host.wr(ntwr_pkg::IDX_UPDATE_XFER, 8'h01, 4'h1, r);
    wait_pulses(p);
    chk(64'(p), 64'h1);
    chk(64'(nco_freq_step), 64'hab8967452310);
    chk(64'(nco_update_index), 64'h3);
    i_ntwr_host.rd(ntwr_pkg::IDX_UPDATE_STAT, d, r);
    chk(64'(d), 64'h0);
  endtask : t_transfer

  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values();
    t_bytes();
    t_refused();
    t_transfer();
    wrap_up();
  end

  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    wrap_up();
  end
endmodule : ntwr_regs_tb
